// ===== pkg/restart_pkg.sv
// Register map, restart images and shared types of the restart state loader.
package restart_pkg;
  // Register byte offsets of single words.
  localparam logic [11:0] OFF_STATUS = 12'h000;
  localparam logic [11:0] OFF_CTRL = 12'h004;
  localparam logic [11:0] OFF_CTL0_LO = 12'h008;
  localparam logic [11:0] OFF_CTL0_HI = 12'h00C;
  localparam logic [11:0] OFF_ACC = 12'h010;
  localparam logic [11:0] OFF_DEXT = 12'h014;
  localparam logic [11:0] OFF_FCW = 12'h018;
  localparam logic [11:0] OFF_FTAG = 12'h01C;
  localparam logic [11:0] OFF_VCSR = 12'h020;
  localparam logic [11:0] OFF_SMB = 12'h024;
  localparam logic [11:0] OFF_CS = 12'h028;
  localparam logic [11:0] OFF_CS_BLO = 12'h02C;
  localparam logic [11:0] OFF_CS_BHI = 12'h030;
  localparam logic [11:0] OFF_DS = 12'h034;
  localparam logic [11:0] OFF_ATTR_SEG = 12'h038;
  localparam logic [11:0] OFF_ATTR_LT = 12'h03C;
  localparam logic [11:0] OFF_FPTR = 12'h040;
  localparam logic [11:0] OFF_FOFF = 12'h044;
  localparam logic [11:0] OFF_FDOFF = 12'h048;
  localparam logic [11:0] OFF_FOP = 12'h04C;
  localparam logic [11:0] OFF_LT = 12'h050;
  localparam logic [11:0] OFF_TK = 12'h054;
  localparam logic [11:0] OFF_RFL = 12'h058;
  localparam logic [11:0] OFF_RIP = 12'h05C;
  localparam logic [11:0] OFF_CR8 = 12'h060;
  localparam logic [11:0] OFF_DR6 = 12'h064;
  localparam logic [11:0] OFF_DR7 = 12'h068;
  localparam logic [11:0] OFF_TSC_LO = 12'h06C;
  localparam logic [11:0] OFF_TSC_HI = 12'h070;
  localparam logic [11:0] OFF_END = 12'h074;
  // Bases of the register arrays.
  localparam logic [11:0] GPR_BASE = 12'h080;
  localparam logic [11:0] MEDIA_BASE = 12'h0C0;
  localparam logic [11:0] FPR_BASE = 12'h100;
  localparam logic [11:0] VEC_BASE = 12'h200;
  localparam logic [3:0] GPR_COUNT = 4'hE;
  // Control register zero image and field positions.
  localparam logic [63:0] CTL0_INIT = 64'h0000_0000_6000_0010;
  localparam int unsigned CTL0_CDIS = 30;
  localparam int unsigned CTL0_NWT = 29;
  localparam int unsigned CTL0_B4 = 4;
  localparam logic [63:0] CTL0_KEEP = (64'h1 << CTL0_CDIS) | (64'h1 << CTL0_NWT);
  localparam logic [63:0] CTL0_FORCE = 64'h1 << CTL0_B4;
  // Other restart images.
  localparam logic [31:0] ACC_FAIL = 32'h0000_0001;
  localparam logic [15:0] FCW_INIT = 16'h0040;
  localparam logic [15:0] FSW_INIT = 16'h0000;
  localparam logic [15:0] FTAG_INIT = 16'h5555;
  localparam logic [31:0] VCSR_INIT = 32'h0000_1F80;
  localparam logic [31:0] SMB_INIT = 32'h0003_0000;
  localparam logic [31:0] RFL_INIT = 32'h0000_0002;
  localparam logic [31:0] RIP_INIT = 32'h0000_FFF0;
  localparam logic [31:0] DR6_INIT = 32'hFFFF_0FF0;
  localparam logic [31:0] DR7_INIT = 32'h0000_0400;
  localparam logic [15:0] CS_SEL = 16'hF000;
  localparam logic [63:0] CS_BASE = 64'h0000_0000_FFFF_0000;
  localparam logic [15:0] DS_SEL = 16'h0000;
  localparam logic [15:0] SEG_LIMIT = 16'hFFFF;
  // Hidden attributes {g, db, l, p, dpl[1:0], s, type[3:0]}.
  localparam logic [10:0] ATTR_CODE = 11'h09A;
  localparam logic [10:0] ATTR_DATA = 11'h092;
  localparam logic [10:0] ATTR_LDT = 11'h082;
  localparam logic [10:0] ATTR_TSS = 11'h083;
  // Identification fields; the values are arbitrary.
  localparam logic [7:0] ID_XFAM = 8'h00;
  localparam logic [3:0] ID_XMOD = 4'h1;
  localparam logic [3:0] ID_FAM = 4'h6;
  localparam logic [3:0] ID_MOD = 4'h2;
  localparam logic [3:0] ID_STEP = 4'h3;
  localparam logic [31:0] DEXT_ID = {4'h0, ID_XFAM, ID_XMOD, 4'h0, ID_FAM, ID_MOD, ID_STEP};
  // Election slot length in cycles, and bus answers.
  localparam logic [7:0] ELECT_SLOT = 8'h08;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_DEC = 2'h3;
  // Shared types.
  typedef enum logic [2:0] {PH_HOLD, PH_LOAD, PH_INVAL, PH_ELECT, PH_WAIT, PH_RUN} phase_t;
  typedef enum logic [2:0] {RG_NONE, RG_FIX, RG_GPR, RG_MEDIA, RG_FPR, RG_VEC} region_t;
  typedef struct packed {
    logic [15:0] sel;
    logic [63:0] base;
    logic [15:0] limit;
    logic [10:0] attr;
  } seg_t;
  typedef struct packed {
    logic cold_n;
    logic warm;
    logic st_run;
    logic st_fail;
    logic inval_done;
    logic claim_n;
    logic peer_done;
    logic solo;
    logic [3:0] proc_id;
  } pin_t;
  typedef struct packed {
    logic [24:0] pad;
    logic cold;
    logic bsp;
    logic rel;
    logic fetch;
    phase_t ph;
  } status_t;
endpackage

// ===== rtl/boot_elect.sv
// Bootstrap processor election by staggered claim on a shared line.
`timescale 1ns/1ps
module boot_elect (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Election control from the loader.
  input wire logic start,
  input wire logic solo,
  input wire logic claim_seen,
  input wire logic [3:0] proc_id,
  // Election result, held until the next start.
  output logic done,
  output logic win
);
  import restart_pkg::*;

  typedef struct packed {
    logic busy;
    logic done;
    logic win;
    logic [7:0] cnt;
  } elect_t;

  elect_t e_q;
  elect_t e_d;
  logic [7:0] slot_cnt;

  // Starting count of the wait, set by this processor's id.
  assign slot_cnt = 8'(({1'b0, proc_id} + 5'h01) * ELECT_SLOT);

  // Each processor waits a slot count set by its id; a claim seen first makes it lose.
  // In the first counting cycle the synchronised line may still show this processor's
  // own claim from before a warm restart, so a claim is only honoured after that cycle.
  always_comb begin
    e_d = e_q;
    if (start) begin
      e_d.busy = !solo;
      e_d.done = solo;
      e_d.win = solo;
      e_d.cnt = slot_cnt;
    end else if (e_q.busy) begin
      if (claim_seen && (e_q.cnt != slot_cnt)) begin
        e_d.busy = 1'b0;
        e_d.done = 1'b1;
        e_d.win = 1'b0;
      end else if (e_q.cnt == 8'h00) begin
        e_d.busy = 1'b0;
        e_d.done = 1'b1;
        e_d.win = 1'b1;
      end else begin
        e_d.cnt = e_q.cnt - 8'h01;
      end
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      e_q <= '0;
    end else begin
      e_q <= e_d;
    end
  end

  assign done = e_q.done;
  assign win = e_q.win;
endmodule

// ===== rtl/restart_state_loader.sv
// Restart state loader: cold and warm restart images, election, register slave.
`timescale 1ns/1ps
module restart_state_loader (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Restart, self-test, cache, election and peer pins.
  input wire restart_pkg::pin_t pins,
  // Core and system outputs.
  output logic fetch_enable,
  output logic cache_inval_req,
  output logic claim_o,
  output logic claim_oe_n,
  output logic init_done_o,
  output logic is_bootstrap,
  // AXI4-Lite write channels.
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels.
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import restart_pkg::*;

  typedef struct packed {
    pin_t m1;
    pin_t m2;
    logic warm3;
    phase_t ph;
    logic cold;
    logic bsp;
    logic rel;
    logic fetch;
    logic inval;
    logic elect_go;
    logic claim_oe_n;
    logic [63:0] ctl0;
    logic [31:0] acc;
    logic [31:0] dext;
    logic [13:0][31:0] gpr;
    logic [31:0] rfl;
    logic [31:0] rip;
    logic [31:0] cr8;
    logic [31:0] dr6;
    logic [31:0] dr7;
    logic [63:0] tsc;
    logic [7:0][79:0] fpr;
    logic [15:0] fcw;
    logic [15:0] fsw;
    logic [15:0] ftag;
    logic [15:0] fcs;
    logic [15:0] fds;
    logic [31:0] foff;
    logic [31:0] fdoff;
    logic [10:0] fop;
    logic [7:0][63:0] media;
    logic [15:0][127:0] vec;
    logic [31:0] vcsr;
    logic [31:0] smb;
    seg_t cs;
    seg_t ds;
    seg_t lt;
    seg_t tk;
    logic awready;
    logic wready;
    logic aw_ok;
    logic w_ok;
    logic [11:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t s_q;
  state_t d;
  logic el_done;
  logic el_win;
  logic warm_rise;
  logic [11:0] wa;
  logic [31:0] wm;

  // Sorts a byte address into the fixed words or one of the arrays.
  function automatic region_t region(input logic [11:0] a);
    if (a[11:8] == VEC_BASE[11:8]) return RG_VEC;
    if (a[11:7] == FPR_BASE[11:7] && a[3:2] != 2'h3) return RG_FPR;
    if (a[11:6] == MEDIA_BASE[11:6]) return RG_MEDIA;
    if (a[11:6] == GPR_BASE[11:6] && a[5:2] < GPR_COUNT) return RG_GPR;
    if (a < OFF_END) return RG_FIX;
    return RG_NONE;
  endfunction

  // Returns the word at a byte address; unmapped words read zero.
  function automatic logic [31:0] rd(input state_t s, input logic [11:0] a);
    unique case (region(a))
      RG_VEC: return s.vec[a[7:4]][{a[3:2], 5'h00} +: 32];
      RG_FPR: begin
        if (a[3:2] == 2'h2) return {16'h0000, s.fpr[a[6:4]][79:64]};
        return s.fpr[a[6:4]][{a[2], 5'h00} +: 32];
      end
      RG_MEDIA: return s.media[a[5:3]][{a[2], 5'h00} +: 32];
      RG_GPR: return s.gpr[a[5:2]];
      RG_FIX: begin
        case ({a[11:2], 2'h0})
          OFF_STATUS: return status_t'{pad: '0, cold: s.cold, bsp: s.bsp, rel: s.rel,
                                       fetch: s.fetch, ph: s.ph};
          OFF_CTRL: return {31'h0, s.rel};
          OFF_CTL0_LO: return s.ctl0[31:0];
          OFF_CTL0_HI: return s.ctl0[63:32];
          OFF_ACC: return s.acc;
          OFF_DEXT: return s.dext;
          OFF_FCW: return {s.fsw, s.fcw};
          OFF_FTAG: return {16'h0000, s.ftag};
          OFF_VCSR: return s.vcsr;
          OFF_SMB: return s.smb;
          OFF_CS: return {s.cs.limit, s.cs.sel};
          OFF_CS_BLO: return s.cs.base[31:0];
          OFF_CS_BHI: return s.cs.base[63:32];
          OFF_DS: return {s.ds.limit, s.ds.sel};
          OFF_ATTR_SEG: return {10'h000, s.ds.attr, s.cs.attr};
          OFF_ATTR_LT: return {10'h000, s.tk.attr, s.lt.attr};
          OFF_FPTR: return {s.fds, s.fcs};
          OFF_FOFF: return s.foff;
          OFF_FDOFF: return s.fdoff;
          OFF_FOP: return {21'h00_0000, s.fop};
          OFF_LT: return {s.lt.limit, s.lt.sel};
          OFF_TK: return {s.tk.limit, s.tk.sel};
          OFF_RFL: return s.rfl;
          OFF_RIP: return s.rip;
          OFF_CR8: return s.cr8;
          OFF_DR6: return s.dr6;
          OFF_DR7: return s.dr7;
          OFF_TSC_LO: return s.tsc[31:0];
          OFF_TSC_HI: return s.tsc[63:32];
          default: return 32'h0000_0000;
        endcase
      end
      RG_NONE: return 32'h0000_0000;
    endcase
  endfunction

  // Merges written bytes into the old word under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
  endfunction

  // Election among processors sharing the claim line.
  boot_elect u_elect (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(s_q.elect_go),
    .solo(s_q.m2.solo),
    .claim_seen(!s_q.m2.claim_n),
    .proc_id(s_q.m2.proc_id),
    .done(el_done),
    .win(el_win)
  );

  // Next-state logic: pin sync, counter, bus slave, then the restart sequence.
  always_comb begin
    d = s_q;
    d.m1 = pins;
    d.m2 = s_q.m1;
    d.warm3 = s_q.m2.warm;
    warm_rise = s_q.m2.warm && !s_q.warm3;
    d.tsc = s_q.tsc + 64'h1;
    wa = {s_q.waddr[11:2], 2'h0};
    wm = merge(rd(s_q, wa), s_q.wdata, s_q.wstrb);
    // Write address and data are taken in either order.
    if (awvalid && s_q.awready) begin
      d.aw_ok = 1'b1;
      d.waddr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      d.w_ok = 1'b1;
      d.wdata = wdata;
      d.wstrb = wstrb;
    end
    if (s_q.bvalid && bready) d.bvalid = 1'b0;
    // Both halves held: perform the write and answer.
    if (s_q.aw_ok && s_q.w_ok && !s_q.bvalid) begin
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = (region(wa) == RG_NONE) ? RESP_DEC : RESP_OK;
      unique case (region(wa))
        RG_VEC: d.vec[wa[7:4]][{wa[3:2], 5'h00} +: 32] = wm;
        RG_FPR: begin
          if (wa[3:2] == 2'h2) d.fpr[wa[6:4]][79:64] = wm[15:0];
          else d.fpr[wa[6:4]][{wa[2], 5'h00} +: 32] = wm;
        end
        RG_MEDIA: d.media[wa[5:3]][{wa[2], 5'h00} +: 32] = wm;
        RG_GPR: d.gpr[wa[5:2]] = wm;
        RG_FIX: begin
          case (wa)
            OFF_CTRL: d.rel = wm[0];
            OFF_CTL0_LO: d.ctl0[31:0] = wm;
            OFF_CTL0_HI: d.ctl0[63:32] = wm;
            OFF_ACC: d.acc = wm;
            OFF_FCW: {d.fsw, d.fcw} = wm;
            OFF_FTAG: d.ftag = wm[15:0];
            OFF_VCSR: d.vcsr = wm;
            OFF_SMB: d.smb = wm;
            OFF_CR8: d.cr8 = wm;
            default: ;
          endcase
        end
        RG_NONE: ;
      endcase
    end
    // Read: one answer per address, data sampled when the address is taken.
    if (s_q.rvalid && rready) d.rvalid = 1'b0;
    if (arvalid && s_q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = rd(s_q, {araddr[11:2], 2'h0});
      d.rresp = (region(araddr) == RG_NONE) ? RESP_DEC : RESP_OK;
    end
    // Restart sequence.
    unique case (s_q.ph)
      PH_HOLD: begin
        d.cold = 1'b1;
        if (s_q.m2.cold_n) d.ph = PH_LOAD;
      end
      PH_LOAD: begin
        // Values common to both restart kinds, all in this one cycle.
        d.ctl0 = s_q.cold ? CTL0_INIT : ((s_q.ctl0 & CTL0_KEEP) | CTL0_FORCE);
        d.acc = (s_q.cold && s_q.m2.st_run && s_q.m2.st_fail) ? ACC_FAIL : '0;
        d.dext = DEXT_ID;
        d.gpr = '0;
        d.rfl = RFL_INIT;
        d.rip = RIP_INIT;
        d.dr6 = DR6_INIT;
        d.dr7 = DR7_INIT;
        d.cs = '{sel: CS_SEL, base: CS_BASE, limit: SEG_LIMIT, attr: ATTR_CODE};
        d.ds = '{sel: DS_SEL, base: '0, limit: SEG_LIMIT, attr: ATTR_DATA};
        d.lt = '{sel: DS_SEL, base: '0, limit: SEG_LIMIT, attr: ATTR_LDT};
        d.tk = '{sel: DS_SEL, base: '0, limit: SEG_LIMIT, attr: ATTR_TSS};
        d.rel = 1'b0;
        d.bsp = 1'b0;
        d.claim_oe_n = 1'b1;
        if (s_q.cold) begin
          // Float, media, vector, save base and counter only on cold.
          d.fpr = '0;
          d.fcw = FCW_INIT;
          d.fsw = FSW_INIT;
          d.ftag = FTAG_INIT;
          d.fcs = '0;
          d.fds = '0;
          d.foff = '0;
          d.fdoff = '0;
          d.fop = '0;
          d.media = '0;
          d.vec = '0;
          d.vcsr = VCSR_INIT;
          d.smb = SMB_INIT;
          d.cr8 = '0;
          d.tsc = '0;
          d.ph = PH_INVAL;
        end else begin
          d.ph = PH_ELECT;
        end
      end
      PH_INVAL: begin
        if (s_q.m2.inval_done) d.ph = PH_ELECT;
      end
      PH_ELECT: begin
        // The first cycle still sees the previous result, so it is skipped.
        if (el_done && !s_q.elect_go) begin
          d.bsp = el_win;
          d.claim_oe_n = !el_win;
          d.ph = el_win ? PH_RUN : PH_WAIT;
        end
      end
      PH_WAIT: begin
        if (s_q.m2.peer_done) d.ph = PH_RUN;
      end
      PH_RUN: ;
      default: d.ph = PH_HOLD;
    endcase
    // Restart requests override everything; cold wins over warm.
    if (warm_rise) begin
      d.ph = PH_LOAD;
      d.cold = 1'b0;
    end
    if (!s_q.m2.cold_n) d.ph = PH_HOLD;
    d.fetch = (d.ph == PH_RUN);
    d.inval = (d.ph == PH_INVAL);
    d.elect_go = (d.ph == PH_ELECT) && (s_q.ph != PH_ELECT);
    d.awready = !d.aw_ok && !d.bvalid;
    d.wready = !d.w_ok && !d.bvalid;
    d.arready = !d.rvalid;
  end

  // State register; reset leaves the claim line released.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.claim_oe_n <= 1'b1;
    end else begin
      s_q <= d;
    end
  end

  // Outputs straight from the state register, except claim_o, which is tied low.
  assign fetch_enable = s_q.fetch;
  assign cache_inval_req = s_q.inval;
  assign claim_o = 1'b0;
  assign claim_oe_n = s_q.claim_oe_n;
  assign init_done_o = s_q.rel;
  assign is_bootstrap = s_q.bsp;
  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arready;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
endmodule

// ===== sim/restart_loader_props.sv
// Concurrent checks on the ports of the restart state loader.
`timescale 1ns/1ps
module restart_loader_props (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Restart side.
  input wire restart_pkg::pin_t pins,
  input wire logic fetch_enable,
  input wire logic cache_inval_req,
  input wire logic claim_o,
  input wire logic claim_oe_n,
  input wire logic is_bootstrap,
  // Register bus.
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid
);
  import restart_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Address and data of one write taken at the same edge.
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  // A read taken in the gap between the single words and the general registers.
  sequence gap_read;
    arvalid && arready && araddr >= OFF_END && araddr < GPR_BASE;
  endsequence
  a_cold_stops_fetch: assert property ((!pins.cold_n) [*4] |=> !fetch_enable)
    else $error("fetch enabled while cold restart held");
  a_inval_no_fetch: assert property (cache_inval_req |-> !fetch_enable)
    else $error("fetch enabled during invalidation");
  a_inval_waits: assert property (cache_inval_req && !pins.inval_done && pins.cold_n
    && !pins.warm |=> cache_inval_req)
    else $error("invalidation request dropped early");
  a_boot_only: assert property (fetch_enable && !is_bootstrap |-> $past(pins.peer_done, 2))
    else $error("non-bootstrap fetch before init done");
  a_claim_winner: assert property (!claim_oe_n |-> is_bootstrap && !claim_o)
    else $error("claim driven by a non-winner");
  a_wr_answer: assert property (wr_taken |-> ##2 bvalid)
    else $error("write response late");
  a_rd_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  a_gap_decode: assert property (gap_read |=> rvalid && rresp == RESP_DEC && rdata == 32'h0)
    else $error("gap read not refused");
  a_busy_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
endmodule

bind restart_state_loader restart_loader_props u_props (
  .aclk(aclk), .aresetn(aresetn), .pins(pins), .fetch_enable(fetch_enable),
  .cache_inval_req(cache_inval_req), .claim_o(claim_o), .claim_oe_n(claim_oe_n),
  .is_bootstrap(is_bootstrap), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .araddr(araddr), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid)
);

// ===== sim/restart_sys_model.sv
// Behavioural model of the system logic that restarts the loader.
`timescale 1ns/1ps
module restart_sys_model (
  // Clock.
  input wire logic aclk,
  // Requests from the bench.
  input wire logic cold_req,
  input wire logic warm_req,
  input wire logic fail,
  input wire logic solo,
  input wire logic rival,
  input wire logic peer,
  input wire logic slow,
  // Loader outputs.
  input wire logic cache_inval_req,
  input wire logic claim_o,
  input wire logic claim_oe_n,
  // Pins toward the loader.
  output restart_pkg::pin_t pins
);
  import restart_pkg::*;
  logic [3:0] wait_q;
  logic done_q;
  // Invalidation ends some cycles after the request and falls with it.
  always_ff @(posedge aclk) begin
    if (!cache_inval_req) begin
      wait_q <= 4'h0;
      done_q <= 1'b0;
    end else if (wait_q == (slow ? 4'h9 : 4'h2)) begin
      done_q <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
  // The claim line is a wired AND of this loader and a rival processor.
  assign pins = {!cold_req, warm_req, 1'b1, fail, done_q,
                 !rival && (claim_oe_n || claim_o), peer, solo, 4'h3};
endmodule

// ===== sim/processor_restart_state_loader_tb_top.sv
// Self-checking bench for the restart state loader.
`timescale 1ns/1ps
module processor_restart_state_loader_tb_top;
  import restart_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic cold_req = 1'b0, warm_req = 1'b0, fail = 1'b0, solo = 1'b1;
  logic rival = 1'b0, peer = 1'b0, slow = 1'b0, inval_seen = 1'b0;
  logic fetch_enable, cache_inval_req, claim_o, claim_oe_n, init_done_o, is_bootstrap;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  pin_t pins;
  int err_total = 0, checked = 0, cyc = 0;
  int seed = 32'h721c;
  logic [31:0] wv [12];
  localparam logic [11:0] AL [27] = '{OFF_ACC, OFF_CTL0_LO, OFF_CTL0_HI, OFF_FCW, OFF_FTAG,
    OFF_VCSR, OFF_SMB, 12'h084, 12'h0B4, 12'h0C0, 12'h100, 12'h2F8, OFF_DEXT, OFF_CS,
    OFF_CS_BLO, OFF_CS_BHI, OFF_DS, OFF_ATTR_SEG, OFF_ATTR_LT, OFF_FPTR, OFF_FOP, OFF_LT, OFF_TK,
    OFF_RFL, OFF_RIP, OFF_DR6, OFF_DR7};

  restart_state_loader dut (.aclk(aclk), .aresetn(aresetn), .pins(pins),
    .fetch_enable(fetch_enable), .cache_inval_req(cache_inval_req), .claim_o(claim_o),
    .claim_oe_n(claim_oe_n), .init_done_o(init_done_o), .is_bootstrap(is_bootstrap),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  restart_sys_model u_sys (.aclk(aclk), .cold_req(cold_req), .warm_req(warm_req),
    .fail(fail), .solo(solo), .rival(rival), .peer(peer), .slow(slow),
    .cache_inval_req(cache_inval_req), .claim_o(claim_o), .claim_oe_n(claim_oe_n), .pins(pins));

  // Clock of 4 ns period.
  initial forever #2 aclk = ~aclk;
  // Hang limit and a record of any invalidation request.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cache_inval_req === 1'b1) inval_seen <= 1'b1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One write; address and data are released at the edge that takes them.
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] rs;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
    cmp(32'(rs), 32'(er));
  endtask
  // One read; data and answer are taken at the edge where rvalid is seen.
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
  endtask
  task automatic chk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rs;
    rd(a, v, rs);
    cmp(v, e);
    cmp(32'(rs), 32'(RESP_OK));
  endtask
  // Waits a bounded time for the core to be let fetch.
  task automatic run_wait();
    int n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (fetch_enable !== 1'b1 && n < 500);
    cmp(32'(fetch_enable), 32'h1);
  endtask
  task automatic restart(input logic cold, input logic f);
    @(posedge aclk);
    cold_req <= cold;
    warm_req <= !cold;
    fail <= f;
    repeat (4) @(posedge aclk);
    cold_req <= 1'b0;
    warm_req <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask
  // Word images after a cold restart.
  function automatic logic [31:0] cold_val(input logic [11:0] a);
    case (a)
      OFF_CTL0_LO: return 32'h6000_0010;
      OFF_RFL: return RFL_INIT;
      OFF_RIP: return RIP_INIT;
      OFF_DR6: return DR6_INIT;
      OFF_DR7: return DR7_INIT;
      OFF_FCW: return 32'h0000_0040;
      OFF_FTAG: return 32'h0000_5555;
      OFF_VCSR: return 32'h0000_1F80;
      OFF_SMB: return 32'h0003_0000;
      OFF_DEXT: return DEXT_ID;
      OFF_CS: return 32'hFFFF_F000;
      OFF_CS_BLO, OFF_DS, OFF_LT, OFF_TK: return 32'hFFFF_0000;
      OFF_ATTR_SEG: return {10'h000, 11'h092, 11'h09A};
      OFF_ATTR_LT: return {10'h000, 11'h083, 11'h082};
      default: return 32'h0000_0000;
    endcase
  endfunction
  // Word images after a warm restart that follows the random writes.
  function automatic logic [31:0] warm_val(input int i);
    case (AL[i])
      OFF_CTL0_LO: return (wv[i] & 32'h6000_0000) | 32'h0000_0010;
      OFF_ACC, OFF_CTL0_HI, 12'h084, 12'h0B4: return 32'h0000_0000;
      default: return (i < 12) ? wv[i] : cold_val(AL[i]);
    endcase
  endfunction
  task automatic sweep(input logic warm, input int from);
    for (int i = from; i < 27; i++) begin
      chk(AL[i], warm ? warm_val(i) : cold_val(AL[i]));
    end
  endtask
  task automatic summarize();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence: power-up, warm, failing cold, bus corners, election.
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    run_wait();
    cmp(32'(inval_seen), 32'h1);
    sweep(1'b0, 0);
    for (int i = 0; i < 12; i++) begin
      wv[i] = $random(seed);
      if (AL[i] == OFF_FTAG) wv[i][31:16] = 16'h0000;
      wr(AL[i], wv[i], RESP_OK);
    end
    inval_seen <= 1'b0;
    restart(1'b0, 1'b0);
    run_wait();
    cmp(32'(inval_seen), 32'h0);
    sweep(1'b1, 0);
    slow <= 1'b1;
    restart(1'b1, 1'b1);
    run_wait();
    cmp(32'(inval_seen), 32'h1);
    rd(OFF_ACC, d, r);
    cmp(32'(d != 32'h0000_0000), 32'h1);
    sweep(1'b0, 1);
    rd(12'h078, d, r);
    cmp(d, 32'h0000_0000);
    cmp(32'(r), 32'(RESP_DEC));
    wr(12'h07C, 32'h1234_5678, RESP_DEC);
    wr(OFF_DEXT, $random(seed), RESP_OK);
    chk(OFF_DEXT, DEXT_ID);
    wr(OFF_CTRL, 32'h0000_0001, RESP_OK);
    cmp(32'(init_done_o), 32'h1);
    solo <= 1'b0;
    rival <= 1'b1;
    restart(1'b1, 1'b0);
    repeat (100) @(posedge aclk);
    cmp(32'(fetch_enable), 32'h0);
    cmp(32'(is_bootstrap), 32'h0);
    cmp(32'(claim_oe_n), 32'h1);
    peer <= 1'b1;
    run_wait();
    cmp(32'(is_bootstrap), 32'h0);
    rival <= 1'b0;
    restart(1'b1, 1'b0);
    peer <= 1'b0;
    run_wait();
    cmp(32'(is_bootstrap), 32'h1);
    cmp(32'(claim_oe_n), 32'h0);
    cmp(32'(claim_o), 32'h0);
    // A warm restart of the winner must not lose to its own earlier claim.
    restart(1'b0, 1'b0);
    run_wait();
    cmp(32'(is_bootstrap), 32'h1);
    summarize();
  end
endmodule
